// >>> rtl/bic_combine.v
// Purpose: overcurrent and input-combination configuration of an H-bridge driver
// Assumes: pins are asynchronous; register access only through the serial target
// Notes: outputs registered; fault monitoring on the pin is optional
//
// How it works
// R1: filter code picks 6/3/1.5/0.2 us overcurrent filter
// R2: threshold code gives 100, 75 or 50 percent
// R3: shutoff pin/bit combine select, OR or AND
// R4: input1 pin/bit combine select, OR or AND
// R5: input2 pin/bit combine select, OR or AND
// R6: config at 0Dh resets 04h, bit5 reads zero
// R7: host pulses wake pin at wake-up (hardwired)
// R8: host may tie input pins low if unused
// R9: host may tie shutoff pin low if unused
// R10: all diagnostics readable from status register
// R11: independent half-bridge off only in serial variant
// R12: input register locked at reset, 10b unlocks
// R13: input register holds shutoff, input1, input2 bits
// R14: locked: pins alone drive the bridge
`timescale 1ns/1ps
`default_nettype none
`include "bic_regs.vh"
module bic_combine (
  // clock and reset
  input wire mclk,
  input wire nrst,
  // serial pins
  input wire spi_sclk,
  input wire spi_cs_n,
  input wire spi_sdi,
  output wire spi_sdo,
  output wire spi_sdo_oe,
  // control pins
  input wire bridge_shutoff_pin,
  input wire enable_or_input1_pin,
  input wire phase_or_input2_pin,
  // raw overcurrent comparator
  input wire overcurrent_raw,
  // to the power stage
  output reg shutoff_out,
  output reg shutoff2_out,
  output reg input1_out,
  output reg input2_out,
  output reg [1:0] threshold_scale_out,
  output reg overcurrent_detected,
  output reg fault_output_n
);
  reg [3:0] pin_meta_reg;
  reg [3:0] pin_sync_reg;
  reg [7:0] config_reg;
  reg [1:0] lock_reg;
  reg [3:0] input_reg;
  reg fault_reg;
  reg [7:0] filt_cnt_reg;
  reg [7:0] filt_limit;
  reg [7:0] rd_data;
  reg [1:0] scale_next;
  wire [5:0] reg_addr;
  wire [7:0] wr_data;
  wire wr_stb;
  wire unlocked;
  wire oc_s;
  wire clr_fault;
  wire oc_hit;
  wire [2:0] comb_next;
  wire shut2_next;

  bic_spi u_spi (
    .mclk(mclk),
    .nrst(nrst),
    .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n),
    .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo),
    .spi_sdo_oe(spi_sdo_oe),
    .reg_addr(reg_addr),
    .wr_data(wr_data),
    .wr_stb(wr_stb),
    .rd_data(rd_data),
    .status_byte({7'h00, fault_reg})
  );

  // two-flop synchronisers on all pins
  always @(posedge mclk) begin
    if (!nrst) begin
      pin_meta_reg <= 4'h0;
      pin_sync_reg <= 4'h0;
    end else begin
      pin_meta_reg <= {overcurrent_raw, bridge_shutoff_pin, enable_or_input1_pin,
                       phase_or_input2_pin};
      pin_sync_reg <= pin_meta_reg;
    end
  end
  assign oc_s = pin_sync_reg[3];

  // register writes
  always @(posedge mclk) begin
    if (!nrst) begin
      config_reg <= `BIC_CFG_RESET; // R6
      lock_reg <= `BIC_LOCK_RESET; // R12
      input_reg <= `BIC_IN_RESET; // R13
    end else if (wr_stb) begin
      if (reg_addr == `BIC_ADDR_CONFIG) begin
        config_reg <= wr_data;
        config_reg[`BIC_CFG_UNUSED] <= 1'b0; // R6
      end
      if (reg_addr == `BIC_ADDR_COMMAND) begin
        lock_reg <= wr_data[`BIC_CMD_LOCK_HI:`BIC_CMD_LOCK_LO]; // R12
      end
      if (reg_addr == `BIC_ADDR_INPUT) begin
        input_reg <= wr_data[3:0]; // R13
      end
    end
  end
  assign unlocked = (lock_reg == `BIC_LOCK_OPEN); // R12
  assign clr_fault = wr_stb && (reg_addr == `BIC_ADDR_COMMAND) && wr_data[`BIC_CMD_CLR_FAULT];

  // read mux; clear-fault bit always reads zero
  always @* begin
    case (reg_addr)
      `BIC_ADDR_STATUS: rd_data = {7'h00, fault_reg}; // R10
      `BIC_ADDR_COMMAND: rd_data = {3'h0, lock_reg, 3'h0};
      `BIC_ADDR_INPUT: rd_data = {4'h0, input_reg};
      `BIC_ADDR_CONFIG: rd_data = config_reg; // R6
      default: rd_data = 8'h00;
    endcase
  end

  // per-input combine: pin alone when locked, OR/AND with register bit when open
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_comb
      wire pin_v;
      wire bit_v;
      wire sel_v;
      assign pin_v = pin_sync_reg[gi];
      assign bit_v = (gi == 2) ? input_reg[`BIC_IN_SHUT] : input_reg[gi];
      assign sel_v = config_reg[gi]; // R3 R4 R5
      assign comb_next[gi] = !unlocked ? pin_v : // R14
                             (sel_v ? (pin_v & bit_v) : (pin_v | bit_v));
    end
  endgenerate
  // second half-bridge off follows the shutoff combine, serial variant only
  assign shut2_next = !unlocked ? pin_sync_reg[2] : // R11
                      (config_reg[`BIC_CFG_SHUT_SEL] ?
                       (pin_sync_reg[2] & input_reg[`BIC_IN_SHUT2]) :
                       (pin_sync_reg[2] | input_reg[`BIC_IN_SHUT2]));

  // threshold decode
  always @* begin
    case (config_reg[`BIC_CFG_OCP_HI:`BIC_CFG_OCP_LO])
      2'h0: scale_next = `BIC_OCP_FULL; // R2
      2'h2: scale_next = `BIC_OCP_75; // R2
      default: scale_next = `BIC_OCP_50; // R2
    endcase
  end

  // filter length; counts rounded down, but the pin synchroniser makes detection lag the stated time by two mclk cycles
  always @* begin
    case (config_reg[`BIC_CFG_TOCP_HI:`BIC_CFG_TOCP_LO])
      2'h0: filt_limit = `BIC_TOCP_CYC00; // R1
      2'h1: filt_limit = `BIC_TOCP_CYC01; // R1
      2'h2: filt_limit = `BIC_TOCP_CYC10; // R1
      default: filt_limit = `BIC_TOCP_CYC11; // R1
    endcase
  end
  assign oc_hit = oc_s && (filt_cnt_reg >= filt_limit - 8'h01);

  // overcurrent filter and sticky fault; a hit beats a same-cycle clear
  always @(posedge mclk) begin
    if (!nrst) begin
      filt_cnt_reg <= 8'h00;
      fault_reg <= 1'b0;
    end else begin
      if (!oc_s) begin
        filt_cnt_reg <= 8'h00;
      end else if (!oc_hit) begin
        filt_cnt_reg <= filt_cnt_reg + 8'h01; // R1
      end
      if (oc_hit) begin
        fault_reg <= 1'b1; // R10
      end else if (clr_fault) begin
        fault_reg <= 1'b0;
      end
    end
  end

  // registered outputs
  always @(posedge mclk) begin
    if (!nrst) begin
      shutoff_out <= 1'b0;
      shutoff2_out <= 1'b0;
      input1_out <= 1'b0;
      input2_out <= 1'b0;
      threshold_scale_out <= `BIC_OCP_FULL;
      overcurrent_detected <= 1'b0;
      fault_output_n <= 1'b1;
    end else begin
      shutoff_out <= comb_next[2]; // R3
      shutoff2_out <= shut2_next; // R11
      input1_out <= comb_next[1]; // R4
      input2_out <= comb_next[0]; // R5
      threshold_scale_out <= scale_next; // R2
      overcurrent_detected <= oc_hit;
      fault_output_n <= ~fault_reg;
    end
  end
endmodule // bic_combine
`default_nettype wire

// >>> shared/bic_regs.vh
// Purpose: register map, field layout, reset values and timing counts of the bridge input combiner
// Assumes: 8-bit registers reached over a 16-bit serial frame
// Notes: definitions only
`ifndef BIC_REGS_VH
`define BIC_REGS_VH

// register offsets
`define BIC_ADDR_STATUS 6'h01
`define BIC_ADDR_COMMAND 6'h08
`define BIC_ADDR_INPUT 6'h09
`define BIC_ADDR_CONFIG 6'h0D

// combine config fields
`define BIC_CFG_TOCP_HI 7
`define BIC_CFG_TOCP_LO 6
`define BIC_CFG_UNUSED 5
`define BIC_CFG_OCP_HI 4
`define BIC_CFG_OCP_LO 3
`define BIC_CFG_SHUT_SEL 2
`define BIC_CFG_IN1_SEL 1
`define BIC_CFG_IN2_SEL 0
`define BIC_CFG_RESET 8'h04

// command register fields
`define BIC_CMD_CLR_FAULT 7
`define BIC_CMD_LOCK_HI 4
`define BIC_CMD_LOCK_LO 3
`define BIC_LOCK_RESET 2'h1
`define BIC_LOCK_OPEN 2'h2

// input register fields
`define BIC_IN_SHUT 3
`define BIC_IN_SHUT2 2
`define BIC_IN_IN1 1
`define BIC_IN_IN2 0
`define BIC_IN_RESET 4'hC

// threshold scale codes driven out
`define BIC_OCP_FULL 2'h0
`define BIC_OCP_75 2'h1
`define BIC_OCP_50 2'h2

// frame layout
`define BIC_FRAME_BITS 5'h10
`define BIC_CMD_BITS 5'h08
`define BIC_FRAME_RD_BIT 14

// overcurrent filter times and cycle counts at 40 MHz
`define BIC_CLK_PERIOD_NS 25
`define BIC_TOCP_T00_NS 6000
`define BIC_TOCP_T01_NS 3000
`define BIC_TOCP_T10_NS 1500
`define BIC_TOCP_T11_NS 200
// sized for the 8-bit filter counter; times above over the clock period, rounded down
`define BIC_TOCP_CYC00 8'hF0
`define BIC_TOCP_CYC01 8'h78
`define BIC_TOCP_CYC10 8'h3C
`define BIC_TOCP_CYC11 8'h08

`endif

// >>> rtl/bic_spi.v
// Purpose: serial target that turns 16-bit frames into register reads and writes
// Assumes: sclk idles low, data sampled on rising edge, shifted on falling edge, msb first
// Notes: frame is {0, read, addr[5:0], data[7:0]}; status byte returned first
`timescale 1ns/1ps
`default_nettype none
`include "bic_regs.vh"
module bic_spi (
  // clock and reset
  input wire mclk,
  input wire nrst,
  // serial pins
  input wire spi_sclk,
  input wire spi_cs_n,
  input wire spi_sdi,
  output reg spi_sdo,
  output reg spi_sdo_oe,
  // register side
  output reg [5:0] reg_addr,
  output reg [7:0] wr_data,
  output reg wr_stb,
  input wire [7:0] rd_data,
  input wire [7:0] status_byte
);
  reg [2:0] meta_reg;
  reg [2:0] sync_reg;
  reg sclk_old_reg;
  reg cs_old_reg;
  reg [15:0] in_reg;
  reg [7:0] out_reg;
  reg [4:0] count_reg;
  wire sclk_s;
  wire cs_n_s;
  wire sdi_s;
  wire rise;
  wire fall;
  wire [15:0] in_next;

  assign sclk_s = sync_reg[2];
  assign cs_n_s = sync_reg[1];
  assign sdi_s = sync_reg[0];
  assign rise = sclk_s & ~sclk_old_reg & ~cs_n_s;
  assign fall = ~sclk_s & sclk_old_reg & ~cs_n_s;
  assign in_next = {in_reg[14:0], sdi_s};

  always @(posedge mclk) begin
    if (!nrst) begin
      // idle pin levels, so no false sclk edge follows reset
      meta_reg <= 3'h2;
      sync_reg <= 3'h2;
      sclk_old_reg <= 1'b0;
      cs_old_reg <= 1'b1;
      in_reg <= 16'h0000;
      out_reg <= 8'h00;
      count_reg <= 5'h00;
      spi_sdo <= 1'b0;
      spi_sdo_oe <= 1'b0;
      reg_addr <= 6'h00;
      wr_data <= 8'h00;
      wr_stb <= 1'b0;
    end else begin
      meta_reg <= {spi_sclk, spi_cs_n, spi_sdi};
      sync_reg <= meta_reg;
      sclk_old_reg <= sclk_s;
      cs_old_reg <= cs_n_s;
      spi_sdo_oe <= ~cs_n_s;
      wr_stb <= 1'b0;
      if (cs_old_reg && !cs_n_s) begin
        // frame start: present status msb at once
        count_reg <= 5'h00;
        spi_sdo <= status_byte[7];
        out_reg <= {status_byte[6:0], 1'b0};
      end else if (!cs_old_reg && cs_n_s) begin
        // only complete write frames take effect
        if (count_reg == `BIC_FRAME_BITS && !in_reg[`BIC_FRAME_RD_BIT]) begin
          wr_data <= in_reg[7:0];
          wr_stb <= 1'b1;
        end
      end else if (rise) begin
        in_reg <= in_next;
        if (count_reg != `BIC_FRAME_BITS) begin
          count_reg <= count_reg + 5'h01;
        end
        if (count_reg == (`BIC_CMD_BITS - 5'h01)) begin
          reg_addr <= in_next[5:0];
        end
      end else if (fall) begin
        if (count_reg == `BIC_CMD_BITS) begin
          spi_sdo <= rd_data[7];
          out_reg <= {rd_data[6:0], 1'b0};
        end else begin
          spi_sdo <= out_reg[7];
          out_reg <= {out_reg[6:0], 1'b0};
        end
      end
    end
  end
endmodule // bic_spi
`default_nettype wire

// >>> bench/bic_host.sv
// Purpose: host model that drives serial frames into the combiner
// Assumes: sclk idles low, 4 mclk per phase, inputs move 2 ns after mclk rise
// Notes: sdo captured just before each sclk rise
`timescale 1ns/1ps
`default_nettype none
module bic_host (
  // clock
  input wire logic mclk,
  // serial pins
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_sdi,
  input wire logic spi_sdo
);
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_sdi = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  task automatic xfer(input logic [15:0] f, output logic [7:0] rd);
    logic [15:0] rx;
    rx = 16'h0000;
    spi_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_sdi = f[i];
      tick(4);
      rx = {rx[14:0], spi_sdo};
      spi_sclk = 1'b1;
      tick(4);
      spi_sclk = 1'b0;
    end
    tick(4);
    spi_cs_n = 1'b1;
    // released line shows inverse, never the stale bit
    spi_sdi = ~f[0];
    tick(8);
    rd = rx[7:0];
  endtask
endmodule // bic_host
`default_nettype wire

// >>> bench/bic_combine_assertions.sv
// Purpose: port checker of the combiner
// Assumes: one clock domain, synchronous active-low reset
// Notes: bound from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module bic_combine_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // watched ports
  input wire logic spi_cs_n,
  input wire logic spi_sdo_oe,
  input wire logic overcurrent_raw,
  input wire logic overcurrent_detected,
  input wire logic fault_output_n,
  input wire logic [1:0] threshold_scale_out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  property p_rst; $rose(nrst) |-> fault_output_n && threshold_scale_out == 2'h0 && !spi_sdo_oe;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs off reset values");
  property p_thr; threshold_scale_out != 2'h3; endproperty
  a_thr: assert property (p_thr) else $error("threshold code out of range");
  property p_ocmin; $rose(overcurrent_detected) |-> $past(overcurrent_raw, 4) && $past(overcurrent_raw, 8);
  endproperty
  a_ocmin: assert property (p_ocmin) else $error("overcurrent flagged too soon");
  property p_occlr; !overcurrent_raw [*4] |-> !overcurrent_detected; endproperty
  a_occlr: assert property (p_occlr) else $error("overcurrent flag stuck");
  property p_flt; overcurrent_detected |=> !fault_output_n; endproperty
  a_flt: assert property (p_flt) else $error("fault pin not asserted");
  property p_oeon; $fell(spi_cs_n) |-> ##[2:4] spi_sdo_oe; endproperty
  a_oeon: assert property (p_oeon) else $error("sdo not driven in frame");
  property p_oeoff; spi_cs_n [*4] |-> !spi_sdo_oe; endproperty
  a_oeoff: assert property (p_oeoff) else $error("sdo driven outside frame");
  property p_oesrc; $rose(spi_sdo_oe) |-> !$past(spi_cs_n) && !$past(spi_cs_n, 2); endproperty
  a_oesrc: assert property (p_oesrc) else $error("sdo driven without select");
endmodule // bic_combine_chk
`default_nettype wire

// >>> bench/bic_combine_tb.sv
// Purpose: self-checking bench of the combiner
// Assumes: 40 MHz mclk, frames through the host model
// Notes: 20000-cycle ceiling cuts a hang
`timescale 1ns/1ps
`default_nettype none
module bic_combine_tb;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic shut_pin = 1'b0;
  logic in1_pin = 1'b0;
  logic in2_pin = 1'b0;
  logic oc_raw = 1'b0;
  wire sclk, cs_n, sdi, sdo, oe, shut, shut2, in1, in2, ocd, flt_n;
  wire [1:0] thr;
  wire [7:0] outs = {4'h0, shut, shut2, in1, in2};
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  int fcyc [4] = '{240, 120, 60, 8};
  logic [1:0] thx [4] = '{2'h0, 2'h2, 2'h1, 2'h2};
  logic [7:0] v;
  always #12.5 mclk = ~mclk;
  bic_host u_host (.mclk(mclk), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_sdi(sdi), .spi_sdo(sdo));
  bic_combine u_bic_combine (.mclk(mclk), .nrst(nrst), .spi_sclk(sclk), .spi_cs_n(cs_n),
    .spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe(oe), .bridge_shutoff_pin(shut_pin),
    .enable_or_input1_pin(in1_pin), .phase_or_input2_pin(in2_pin), .overcurrent_raw(oc_raw),
    .shutoff_out(shut), .shutoff2_out(shut2), .input1_out(in1), .input2_out(in2),
    .threshold_scale_out(thr), .overcurrent_detected(ocd), .fault_output_n(flt_n));
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    u_host.xfer({2'b00, a, d}, v);
  endtask
  task automatic rdc(input string what, input logic [5:0] a, input logic [7:0] exp);
    u_host.xfer({2'b01, a, 8'h00}, v);
    check(what, v, exp);
  endtask
  initial begin
    u_host.tick(12);
    nrst = 1'b1;
    u_host.tick(2);
    rdc("config", 6'h0D, 8'h04);
    rdc("input", 6'h09, 8'h0C);
    rdc("unmapped", 6'h3F, 8'h00);
    check("sdo_oe", {7'h00, oe}, 8'h00);
    wr(6'h0D, 8'hFF);
    rdc("config", 6'h0D, 8'hDF);
    $display("test registers done");
    // locked: register bits must not leak through, even with OR selected
    wr(6'h0D, 8'h00);
    wr(6'h09, 8'h0F);
    rdc("input", 6'h09, 8'h0F);
    u_host.tick(4);
    check("locked", outs, 8'h00);
    wr(6'h08, 8'h10);
    for (int k = 0; k < 2; k++) begin
      wr(6'h0D, k ? 8'h07 : 8'h00);
      wr(6'h09, k ? 8'h00 : 8'h0F);
      shut_pin = k[0];
      in1_pin = k[0];
      in2_pin = k[0];
      u_host.tick(4);
      check("combine", outs, k ? 8'h00 : 8'h0F);
    end
    // mixed selects catch a select wired to the wrong input
    wr(6'h0D, 8'h04);
    wr(6'h09, 8'h09);
    shut_pin = 1'b0;
    in1_pin = 1'b1;
    in2_pin = 1'b0;
    u_host.tick(4);
    check("mixed", outs, 8'h03);
    shut_pin = 1'b1;
    u_host.tick(4);
    check("mixed", outs, 8'h0B);
    wr(6'h08, 8'h08);
    check("relock", outs, 8'h0E);
    $display("test combine done");
    for (int i = 0; i < 4; i++) begin
      wr(6'h0D, {i[1:0], 1'b0, i[1:0], 3'b000});
      check("scale", {6'h00, thr}, {6'h00, thx[i]});
      oc_raw = 1'b1;
      u_host.tick(fcyc[i] - 4);
      check("early", {7'h00, ocd}, 8'h00);
      u_host.tick(12);
      check("detect", {6'h00, ocd, flt_n}, 8'h02);
      oc_raw = 1'b0;
      u_host.tick(6);
      rdc("status", 6'h01, 8'h01);
      wr(6'h08, 8'h80);
      check("cleared", {7'h00, flt_n}, 8'h01);
    end
    $display("test overcurrent done");
    // wake-up reset pulse of 30 us restores every register
    nrst = 1'b0;
    u_host.tick(1200);
    nrst = 1'b1;
    u_host.tick(2);
    rdc("config", 6'h0D, 8'h04);
    rdc("lock", 6'h08, 8'h08);
    rdc("input", 6'h09, 8'h0C);
    check("wake", outs, 8'h0E);
    $display("test wake done");
    wrap_up();
  end
endmodule // bic_combine_tb
bind bic_combine bic_combine_chk u_chk (.mclk(mclk), .nrst(nrst), .spi_cs_n(spi_cs_n),
  .spi_sdo_oe(spi_sdo_oe), .overcurrent_raw(overcurrent_raw),
  .overcurrent_detected(overcurrent_detected), .fault_output_n(fault_output_n),
  .threshold_scale_out(threshold_scale_out));
`default_nettype wire
